// ===== design/sio_image.sv
// Serial data interface exchanging byte blocks through a handshake process image.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Status bits: xfer ack, recv req, init ack, overflow.
// - Status bits 4-12 give presented receive count.
// - Length fields nine bits wide, at most 511 bytes per transfer.
// - Transmit toggle copies bytes into send buffer.
// - Transmit acceptance shown by toggling status bit.
// - Receive toggle announces bytes already presented.
// - No new block before previous acknowledged.
// - Init request holds link disabled, clears fills.
// - Init done is acknowledged by init-accepted bit.
// - Overflow flagged when full; further bytes dropped.
// - Image byte count configurable, 16 to 4096.
// - Receive buffer depth configurable, 4096 to 65535.
// - Sync mode services once per task cycle.
// - Otherwise service from fixed one millisecond tick.
module sio_image import sio_image_pkg::*; #(
	parameter int IMAGE_BYTES = 16,
	parameter int RXBUF_DEPTH = 4096,
	parameter int TICK_COUNT = TICK_CYCLES
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic rst_in,
	// Register port.
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	output logic [31:0] rdata_out,
	// Task cycle marker for sync mode.
	input wire logic task_cycle_in,
	// Serial line.
	input wire logic rxd_in,
	output logic txd_out,
	// Interrupt.
	output logic irq_out
);

	// Index widths of the image, the receive ring and the tick counter.
	localparam int IW = $clog2(IMAGE_BYTES);
	localparam int BW = $clog2(RXBUF_DEPTH);
	localparam int TW = $clog2(TICK_COUNT + 1);

	// All registered state of the block apart from the storage arrays.
	// One struct keeps reset and the next-state copy in step for every field.
	typedef struct packed {
		logic [15:0] control;
		logic xfer_ack;
		logic recv_req;
		logic init_ack;
		logic overflow;
		logic [8:0] rx_byte_count;
		logic prev_xfer;
		logic prev_recv;
		logic sync_mode;
		logic [15:0] baud_div;
		logic [2:0] irq_status;
		logic [2:0] irq_mask;
		logic [IW-1:0] data_index;
		logic [8:0] tx_left;
		logic [IW-1:0] tx_ptr;
		logic [BW-1:0] rx_wr;
		logic [BW-1:0] rx_rd;
		logic [BW:0] rx_fill;
		logic [TW-1:0] tick_count;
		logic [2:0] rxd_sync;
		line_s tx;
		line_s rx;
		logic [31:0] rdata;
		logic txd;
		logic irq;
	} state_s;

	state_s cur;
	state_s nxt;
	logic [7:0] tx_image [IMAGE_BYTES];
	logic [7:0] rx_image [IMAGE_BYTES];
	logic [7:0] tx_buf [IMAGE_BYTES];
	logic [7:0] rx_buf [RXBUF_DEPTH];
	reg_req_s req;
	logic service;
	logic rx_push;
	logic [7:0] rx_byte;
	logic tx_load;
	logic present;
	logic [8:0] present_n;

	// Legal configuration range is checked at elaboration.
	// The nine-bit length fields cannot report a full image above 511 bytes.
	if (IMAGE_BYTES < IMAGE_MIN || IMAGE_BYTES > IMAGE_MAX) begin : g_img_chk
		$error("image byte count out of range");
	end
	if (RXBUF_DEPTH < RXBUF_MIN || RXBUF_DEPTH > RXBUF_MAX) begin : g_buf_chk
		$error("receive buffer depth out of range");
	end

	// Status word image, used by the status register read-back.
	// Building it in one place keeps read-back and the bit map from drifting apart.
	function automatic logic [15:0] status_word(input state_s s);
		logic [15:0] w;
		w = 16'h0000;
		w[BIT_XFER] = s.xfer_ack;
		w[BIT_RECV] = s.recv_req;
		w[BIT_INIT] = s.init_ack;
		w[BIT_OVFL] = s.overflow;
		w[LEN_MSB:LEN_LSB] = s.rx_byte_count;
		return w;
	endfunction

	// Ring index step with wrap, used by the write pointer, the read pointer and the copy-out.
	// The modulo keeps depths that are not a power of two working, at the cost of a divider.
	function automatic logic [BW-1:0] ring_add(input logic [BW-1:0] base, input int step);
		logic [31:0] sum;
		sum = 32'(base) + 32'(step);
		return BW'(sum % 32'(RXBUF_DEPTH));
	endfunction

	assign req = '{addr: addr_in, wdata: wdata_in, write: write_in, read: read_in};

	// Combined next-state logic for handshakes, serial engines and registers.
	always_comb begin
		// Strobes default low; read data stay zero unless a read is answered below.
		nxt = cur;
		service = 1'b0;
		rx_push = 1'b0;
		rx_byte = cur.rx.shift;
		tx_load = 1'b0;
		present = 1'b0;
		present_n = 9'h000;
		// The serial input passes two flops before the receiver reads the third one.
		nxt.rxd_sync = {cur.rxd_sync[1:0], rxd_in};
		nxt.rdata = 32'h0000_0000;

		// Service tick: task cycle in sync mode, else fixed millisecond.
		// In sync mode the counter still runs, but its terminal count is ignored.
		if (cur.tick_count >= TW'(TICK_COUNT - 1)) begin
			nxt.tick_count = '0;
		end else begin
			nxt.tick_count = cur.tick_count + 1'b1;
		end
		service = cur.sync_mode ? task_cycle_in : (cur.tick_count >= TW'(TICK_COUNT - 1));

		// Register writes.
		// Unmapped addresses and the read-only status word ignore writes.
		if (req.write) begin
			if (req.addr == REG_CONTROL) begin
				nxt.control = req.wdata[15:0];
			end else if (req.addr == REG_CONFIG) begin
				nxt.sync_mode = req.wdata[CFG_SYNC];
				nxt.baud_div = req.wdata[CFG_DIV_LSB+15:CFG_DIV_LSB];
			end else if (req.addr == REG_IRQ_MASK) begin
				nxt.irq_mask = req.wdata[2:0];
			end else if (req.addr == REG_DATA_INDEX) begin
				nxt.data_index = req.wdata[IW-1:0];
			end
		end

		// Register reads; an interrupt status read clears the interrupt bits.
		// Read data are zero outside the answer cycle, so several slaves can share one bus.
		// Reading the handshake status word leaves the handshake state untouched.
		if (req.read) begin
			if (req.addr == REG_CONTROL) begin
				nxt.rdata = {16'h0000, cur.control};
			end else if (req.addr == REG_STATUS) begin
				nxt.rdata = {16'h0000, status_word(cur)};
			end else if (req.addr == REG_CONFIG) begin
				nxt.rdata = {cur.baud_div, 15'h0000, cur.sync_mode};
			end else if (req.addr == REG_IRQ_STATUS) begin
				nxt.rdata = {29'h0, cur.irq_status};
				nxt.irq_status = 3'h0;
			end else if (req.addr == REG_IRQ_MASK) begin
				nxt.rdata = {29'h0, cur.irq_mask};
			end else if (req.addr == REG_RX_DATA) begin
				nxt.rdata = {24'h0, rx_image[cur.data_index]};
			end else if (req.addr == REG_DATA_INDEX) begin
				nxt.rdata = 32'(cur.data_index);
			end
		end

		// Receive engine with 16x oversampling divider omitted: one bit per baud period.
		// A bit lasts baud_div + 1 cycles: the counter reloads with baud_div and runs to zero.
		// The receiver runs without service slots; bytes collect in the ring until presented.
		if (cur.rx.baud_count != 16'h0000) begin
			nxt.rx.baud_count = cur.rx.baud_count - 1'b1;
		end
		case (cur.rx.state)
			LINE_IDLE: begin
				if (!cur.rxd_sync[2]) begin
					nxt.rx.state = LINE_START;
					nxt.rx.baud_count = {1'b0, cur.baud_div[15:1]};
				end
			end
			LINE_START: begin
				if (cur.rx.baud_count == 16'h0000) begin
					// The start bit is checked again mid-bit, so a short glitch is ignored.
					nxt.rx.state = cur.rxd_sync[2] ? LINE_IDLE : LINE_DATA;
					nxt.rx.baud_count = cur.baud_div;
					nxt.rx.bit_count = 4'h0;
				end
			end
			LINE_DATA: begin
				if (cur.rx.baud_count == 16'h0000) begin
					nxt.rx.shift = {cur.rxd_sync[2], cur.rx.shift[7:1]};
					nxt.rx.baud_count = cur.baud_div;
					nxt.rx.bit_count = cur.rx.bit_count + 1'b1;
					if (cur.rx.bit_count == 4'h7) begin
						nxt.rx.state = LINE_STOP;
					end
				end
			end
			default: begin
				if (cur.rx.baud_count == 16'h0000) begin
					nxt.rx.state = LINE_IDLE;
					// A frame with a low stop bit is dropped; there is no framing-error flag.
					rx_push = cur.rxd_sync[2];
				end
			end
		endcase

		// Buffer full: byte is dropped and overflow is flagged.
		// The flag holds until an init, so a slow controller still learns of the loss.
		if (rx_push && cur.rx_fill == (BW+1)'(RXBUF_DEPTH)) begin
			rx_push = 1'b0;
			nxt.overflow = 1'b1;
			nxt.irq_status[IRQ_OVERFLOW] = 1'b1;
		end
		if (rx_push) begin
			nxt.rx_wr = ring_add(cur.rx_wr, 1);
		end

		// Transmit engine drains the send buffer.
		// Init holds the transmitter idle even while bytes are still waiting.
		if (cur.tx.baud_count != 16'h0000) begin
			nxt.tx.baud_count = cur.tx.baud_count - 1'b1;
		end
		case (cur.tx.state)
			LINE_IDLE: begin
				nxt.txd = 1'b1;
				if (cur.tx_left != 9'h000 && !cur.control[BIT_INIT]) begin
					nxt.tx.shift = tx_buf[cur.tx_ptr];
					nxt.tx_ptr = cur.tx_ptr + 1'b1;
					nxt.tx_left = cur.tx_left - 1'b1;
					nxt.tx.state = LINE_START;
					nxt.tx.baud_count = cur.baud_div;
					nxt.txd = 1'b0;
				end
			end
			LINE_START, LINE_DATA: begin
				if (cur.tx.baud_count == 16'h0000) begin
					nxt.tx.baud_count = cur.baud_div;
					nxt.txd = cur.tx.shift[0];
					nxt.tx.shift = {1'b1, cur.tx.shift[7:1]};
					nxt.tx.bit_count = (cur.tx.state == LINE_START) ? 4'h0 : cur.tx.bit_count + 1'b1;
					nxt.tx.state = (cur.tx.bit_count == 4'h7 && cur.tx.state == LINE_DATA) ?
						LINE_STOP : LINE_DATA;
					if (cur.tx.bit_count == 4'h7 && cur.tx.state == LINE_DATA) begin
						nxt.txd = 1'b1;
					end
				end
			end
			default: begin
				nxt.txd = 1'b1;
				if (cur.tx.baud_count == 16'h0000) begin
					nxt.tx.state = LINE_IDLE;
				end
			end
		endcase

		// Handshake processing, once per service slot.
		// A new transmit toggle waits while the previous block drains, so the copy never
		// overwrites queued bytes; it is acknowledged when copied, not when sent.
		// A block is presented only after the last one was acknowledged, at most one
		// image's worth; the rest waits in the ring for a later slot.
		if (service) begin
			if (cur.control[BIT_XFER] != cur.prev_xfer && cur.tx_left == 9'h000) begin
				nxt.prev_xfer = cur.control[BIT_XFER];
				tx_load = 1'b1;
				nxt.tx_left = cur.control[LEN_MSB:LEN_LSB];
				nxt.tx_ptr = '0;
				nxt.xfer_ack = ~cur.xfer_ack;
				nxt.irq_status[IRQ_TX_DONE] = 1'b1;
			end
			if (cur.control[BIT_RECV] != cur.prev_recv) begin
				nxt.prev_recv = cur.control[BIT_RECV];
				nxt.rx_byte_count = 9'h000;
			end else if (cur.recv_req == cur.prev_recv && cur.rx_fill != '0) begin
				present = 1'b1;
				present_n = (cur.rx_fill > (BW+1)'(IMAGE_BYTES)) ? 9'(IMAGE_BYTES) : 9'(cur.rx_fill);
				nxt.rx_byte_count = present_n;
				nxt.recv_req = ~cur.recv_req;
				nxt.rx_rd = ring_add(cur.rx_rd, int'(present_n));
				nxt.irq_status[IRQ_RX_READY] = 1'b1;
			end
		end

		// Fill level after this cycle's push and take.
		// Push and take may fall in one cycle; both count, so no byte is lost or counted twice.
		nxt.rx_fill = cur.rx_fill + (BW+1)'(rx_push) - (BW+1)'(present_n);

		// Initialisation holds everything idle and clears fill levels.
		// The toggles are realigned to the control word, so leaving init raises no command.
		// Overflow and the receive ring are cleared here and nowhere else.
		if (cur.control[BIT_INIT]) begin
			nxt.rx_fill = '0;
			nxt.rx_wr = '0;
			nxt.rx_rd = '0;
			nxt.tx_left = 9'h000;
			nxt.rx_byte_count = 9'h000;
			nxt.overflow = 1'b0;
			nxt.tx.state = LINE_IDLE;
			nxt.rx.state = LINE_IDLE;
			nxt.txd = 1'b1;
			nxt.prev_xfer = cur.control[BIT_XFER];
			nxt.prev_recv = cur.control[BIT_RECV];
			nxt.recv_req = cur.control[BIT_RECV];
			nxt.init_ack = 1'b1;
			tx_load = 1'b0;
			rx_push = 1'b0;
			present = 1'b0;
		end else begin
			nxt.init_ack = 1'b0;
		end

		// The interrupt follows the next state, so it rises in the cycle its status bit is set.
		nxt.irq = |(nxt.irq_status & nxt.irq_mask);
	end

	// State register.
	// Reset parks the line high and the synchroniser at the idle level, so no false start follows.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			cur <= '0;
			cur.baud_div <= BAUD_DIV_RESET;
			cur.txd <= 1'b1;
			cur.rxd_sync <= 3'h7;
		end else begin
			cur <= nxt;
		end
	end

	// Storage arrays; no reset needed since fill counts guard them.
	// Arrays stay out of reset; the fill counts keep stale bytes from being presented.
	// The send buffer copy decouples the line from later image writes by software.
	always_ff @(posedge mclk_in) begin
		if (req.write && req.addr == REG_TX_DATA) begin
			tx_image[cur.data_index] <= req.wdata[7:0];
		end
		if (tx_load) begin
			tx_buf <= tx_image;
		end
		if (rx_push) begin
			rx_buf[cur.rx_wr] <= rx_byte;
		end
		if (present) begin
			for (int i = 0; i < IMAGE_BYTES; i++) begin
				rx_image[i] <= rx_buf[ring_add(cur.rx_rd, i)];
			end
		end
	end

	// Every output comes straight from a register of the state struct.
	assign rdata_out = cur.rdata;
	assign txd_out = cur.txd;
	assign irq_out = cur.irq;

endmodule : sio_image
`default_nettype wire

// ===== include/sio_image_pkg.sv
// Package with constants, types and register map of the serial process image block.
package sio_image_pkg;

	// Register indices on the plain register port.
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h01;
	localparam logic [7:0] REG_CONFIG = 8'h02;
	localparam logic [7:0] REG_IRQ_STATUS = 8'h03;
	localparam logic [7:0] REG_IRQ_MASK = 8'h04;
	localparam logic [7:0] REG_TX_DATA = 8'h05;
	localparam logic [7:0] REG_RX_DATA = 8'h06;
	localparam logic [7:0] REG_DATA_INDEX = 8'h07;

	// Handshake bit positions, shared by control and status words.
	localparam int BIT_XFER = 0;
	localparam int BIT_RECV = 1;
	localparam int BIT_INIT = 2;
	localparam int BIT_OVFL = 3;
	localparam int LEN_LSB = 4;
	localparam int LEN_MSB = 12;

	// Configuration register fields.
	localparam int CFG_SYNC = 0;
	localparam int CFG_DIV_LSB = 16;

	// Interrupt status bit positions.
	localparam int IRQ_TX_DONE = 0;
	localparam int IRQ_RX_READY = 1;
	localparam int IRQ_OVERFLOW = 2;

	// Image and buffer limits.
	localparam int IMAGE_MIN = 16;
	localparam int IMAGE_MAX = 4096;
	localparam int RXBUF_MIN = 4096;
	localparam int RXBUF_MAX = 65535;

	// Timing: fixed service tick and clock rate.
	localparam int CLK_HZ = 50000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
	localparam logic [15:0] BAUD_DIV_RESET = 16'h01B2;

	// Serial line states.
	typedef enum logic [1:0] {
		LINE_IDLE = 2'b00,
		LINE_START = 2'b01,
		LINE_DATA = 2'b10,
		LINE_STOP = 2'b11
	} line_state_e;

	// One serial engine: state, bit counter, baud counter, shift register.
	typedef struct packed {
		line_state_e state;
		logic [3:0] bit_count;
		logic [15:0] baud_count;
		logic [7:0] shift;
	} line_s;

	// Register-port request carried as one unit.
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic write;
		logic read;
	} reg_req_s;

endpackage : sio_image_pkg

// ===== verification/sio_image_checker.sv
// Assertions on the port behaviour of the serial process image block.
`timescale 1ns/1ps
`default_nettype none
module sio_image_checker import sio_image_pkg::*; #(
	parameter int IMAGE_BYTES = 16
) (
	// Clock, reset and register port.
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [7:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic write_in,
	input wire logic read_in,
	input wire logic [31:0] rdata_out,
	// Task marker, serial line and interrupt.
	input wire logic task_cycle_in,
	input wire logic rxd_in,
	input wire logic txd_out,
	input wire logic irq_out
);
	logic [12:0] ctrl;
	logic [2:0] mask;
	logic rd_st;
	logic rd_ct;
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	// Shadow of control word and mask, since the checker cannot see inside.
	always_ff @(posedge mclk_in) begin
		if (rst_in) begin
			ctrl <= 13'h0;
			mask <= 3'h0;
		end else if (write_in && addr_in == REG_CONTROL) begin
			ctrl <= wdata_in[12:0];
		end else if (write_in && addr_in == REG_IRQ_MASK) begin
			mask <= wdata_in[2:0];
		end
	end
	// Read strobes aimed at status and control.
	assign rd_st = read_in && addr_in == REG_STATUS;
	assign rd_ct = read_in && addr_in == REG_CONTROL;
	idle_rdata_a: assert property (!$past(read_in) |-> rdata_out == 32'h0)
		else $error("read data outside an answer");
	unmapped_zero_a: assert property (read_in && addr_in > REG_DATA_INDEX |=> rdata_out == 32'h0)
		else $error("unmapped read not zero");
	control_echo_a: assert property (rd_ct |=> rdata_out[12:0] == ctrl)
		else $error("control word not read back");
	init_ack_a: assert property (rd_st && ctrl[BIT_INIT] && $past(ctrl[BIT_INIT])
		|=> rdata_out[BIT_INIT] && rdata_out[12:4] == 9'h0) else $error("init not acknowledged");
	init_drop_a: assert property (rd_st && !ctrl[BIT_INIT] && !$past(ctrl[BIT_INIT])
		|=> !rdata_out[BIT_INIT]) else $error("init ack without request");
	init_quiet_a: assert property (ctrl[BIT_INIT] && $past(ctrl[BIT_INIT], 2)
		&& $past(ctrl[BIT_INIT]) |-> txd_out) else $error("line active during init");
	count_bound_a: assert property (rd_st |=> rdata_out[12:4] <= 9'(IMAGE_BYTES))
		else $error("count beyond image");
	masked_irq_a: assert property (mask == 3'h0 && $past(mask) == 3'h0 |-> !irq_out)
		else $error("interrupt while all masked");
	// Main scenarios: interrupt, presented block, transmit frame.
	cover property (irq_out);
	cover property (rd_st ##1 rdata_out[BIT_RECV]);
	cover property (!txd_out);
endmodule // sio_image_checker
bind sio_image sio_image_checker #(.IMAGE_BYTES(IMAGE_BYTES)) i_checker (.mclk_in(mclk_in),
	.rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
	.read_in(read_in), .rdata_out(rdata_out), .task_cycle_in(task_cycle_in),
	.rxd_in(rxd_in), .txd_out(txd_out), .irq_out(irq_out));
`default_nettype wire

// ===== verification/sio_peer.sv
// Serial peer on the far side of the line pins, one start, eight data, one stop bit.
`timescale 1ns/1ps
`default_nettype none
module sio_peer #(
	parameter int DIV = 16
) (
	// Clock and line pins.
	input wire logic mclk_in,
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] got[$];
	logic [7:0] sh;
	// The line idles high, as a pulled-up receive pin would.
	initial line_out = 1'b1;
	// One frame, least significant data bit first.
	task automatic send(input logic [7:0] b);
		for (int i = 0; i < 10; i++) begin
			line_out <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i - 1];
			repeat (DIV) @(posedge mclk_in);
		end
	endtask
	// Samples mid-bit; the start edge is trusted and not checked again.
	always begin
		@(negedge line_in);
		repeat (DIV / 2) @(posedge mclk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (DIV) @(posedge mclk_in);
			sh[i] = line_in;
		end
		repeat (DIV) @(posedge mclk_in);
		got.push_back(sh);
	end
endmodule // sio_peer
`default_nettype wire

// ===== verification/test_sio_image.sv
// Self-checking bench of the serial process image block.
`timescale 1ns/1ps
`default_nettype none
module test_sio_image import sio_image_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic write = 1'b0;
	logic read = 1'b0;
	logic pulse_q = 1'b0;
	logic [31:0] rdata;
	logic rxd;
	logic txd;
	logic irq;
	logic [7:0] rnd = 8'h55;
	logic [31:0] d;
	logic [7:0] sent[$];
	int fail_count = 0;
	int n_compared = 0;
	// Clock of 20 ns period.
	always #10 clk = ~clk;
	// A short service tick keeps the run small and drains the ring long before it fills.
	sio_image #(.TICK_COUNT(50)) i_dut (.mclk_in(clk), .rst_in(rst), .addr_in(addr),
		.wdata_in(wdata), .write_in(write), .read_in(read), .rdata_out(rdata),
		.task_cycle_in(pulse_q), .rxd_in(rxd), .txd_out(txd), .irq_out(irq));
	// The divider field is written as 16; one bit then lasts 17 cycles, a reload plus 16 counts.
	sio_peer #(.DIV(17)) i_peer (.mclk_in(clk), .line_in(txd), .line_out(rxd));
	// Next value of the random sequence.
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Control and status share a layout: toggles low, byte count in 12:4.
	function automatic logic [31:0] word(input logic x, input logic r, input logic i, input int n);
		return {19'h0, 9'(n), 1'b0, i, r, x};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	// Strobe for one edge, then an idle edge so no strobe is set twice at once.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		addr <= a;
		wdata <= v;
		write <= 1'b1;
		@(posedge clk);
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a);
		addr <= a;
		read <= 1'b1;
		@(posedge clk);
		read <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask
	task automatic poll(input int b, input logic v);
		rd(REG_STATUS);
		for (int i = 0; i < 400 && d[b] !== v; i++)
			rd(REG_STATUS);
	endtask
	task automatic pulse();
		pulse_q <= 1'b1;
		@(posedge clk);
		pulse_q <= 1'b0;
		repeat (3) @(posedge clk);
	endtask
	task automatic send(input int n);
		repeat (n) begin
			rnd = lfsr(rnd);
			sent.push_back(rnd);
			i_peer.send(rnd);
		end
	endtask
	task automatic take(input int k, input int n);
		for (int i = 0; i < n; i++) begin
			wr(REG_DATA_INDEX, 32'(i));
			rc(REG_RX_DATA, {24'h0, sent[k + i]});
		end
	endtask
	task automatic conclude();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog, far beyond the few thousand cycles the run needs.
	initial begin
		repeat (30000) @(posedge clk);
		fail_count++;
		conclude();
	end
	// Main sequence: reset, init, transmit on the tick, receive in sync mode.
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(REG_STATUS, word(0, 0, 0, 0));
		rc(REG_CONFIG, {BAUD_DIV_RESET, 16'h0});
		rc(8'hC3, 32'h0);
		wr(REG_CONFIG, 32'h00100000);
		wr(REG_IRQ_MASK, 32'h7);
		rc(REG_IRQ_MASK, 32'h7);
		wr(REG_CONTROL, word(0, 0, 1, 0));
		rc(REG_STATUS, word(0, 0, 1, 0));
		wr(REG_CONTROL, word(0, 0, 0, 0));
		rc(REG_STATUS, word(0, 0, 0, 0));
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr(rnd);
			sent.push_back(rnd);
			wr(REG_DATA_INDEX, 32'(i));
			wr(REG_TX_DATA, {24'h0, rnd});
		end
		rc(REG_DATA_INDEX, 32'h2);
		wr(REG_CONTROL, word(1, 0, 0, 3));
		rc(REG_CONTROL, word(1, 0, 0, 3));
		poll(BIT_XFER, 1'b1);
		chk(d, word(1, 0, 0, 0));
		chk({31'h0, irq}, 32'h1);
		rc(REG_IRQ_STATUS, 32'h1);
		rc(REG_IRQ_STATUS, 32'h0);
		for (int i = 0; i < 3000 && i_peer.got.size() < 3; i++)
			@(posedge clk);
		foreach (sent[i])
			chk({24'h0, i_peer.got[i]}, {24'h0, sent[i]});
		// Bytes received in sync mode wait for a task cycle pulse.
		wr(REG_CONFIG, 32'h00100001);
		wr(REG_IRQ_MASK, 32'h0);
		sent = {};
		send(3);
		rc(REG_STATUS, word(1, 0, 0, 0));
		pulse();
		poll(BIT_RECV, 1'b1);
		chk(d, word(1, 1, 0, 3));
		chk({31'h0, irq}, 32'h0);
		wr(REG_IRQ_MASK, 32'h7);
		take(0, 3);
		chk({31'h0, irq}, 32'h1);
		send(2);
		pulse();
		rc(REG_STATUS, word(1, 1, 0, 3));
		wr(REG_CONTROL, word(1, 1, 0, 0));
		pulse();
		pulse();
		poll(BIT_RECV, 1'b0);
		chk(d, word(1, 0, 0, 2));
		take(3, 2);
		conclude();
	end
endmodule // test_sio_image
`default_nettype wire
